/* include/ppa_pkg.sv */
// Overview of operation
// - Control bit 1 picks input line 1 edge.
// - Control bit 0 gates flag onto interrupt.
// - Input line 1 flag reads as bit 7.
// - Control bit 2 picks output or direction.
// - Direction bit one drives line, zero inputs.
// - Side A pulse mode: low, restore next strobe.
// - Side A output read fires the strobe.
// - Side B write lowers line, edge restores.
// - Control bits 6 and 7 read only.
// - Reset clears data, direction, control and flag registers.
// - Chip and register selects pick register.
// - Output register read clears both flags.
package ppa_pkg;

  // Control register field positions.
  localparam int CTL_IRQ1_EN = 0;
  localparam int CTL_IRQ1_RISE = 1;
  localparam int CTL_VIEW_OUT = 2;
  localparam int CTL_LINE2_B3 = 3;
  localparam int CTL_LINE2_B4 = 4;
  localparam int CTL_LINE2_OUT = 5;
  localparam int CTL_FLAG2 = 6;
  localparam int CTL_FLAG1 = 7;
  localparam int CTL_WR_BITS = 6;

  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [5:0] CTL_RESET = 6'h00;

  localparam logic SIDE_A = 1'b0;
  localparam logic SIDE_B = 1'b1;

  typedef struct packed {
    logic e;
    logic cs0;
    logic cs1;
    logic cs2_n;
    logic rs0;
    logic rs1;
    logic rw;
    logic [7:0] d;
  } ppa_bus_s;

  typedef struct packed {
    logic [7:0] pa;
    logic [7:0] pb;
    logic [1:0] c1;
    logic [1:0] c2;
  } ppa_per_s;

  typedef struct packed {
    logic [7:0] ddr;
    logic [7:0] outr;
    logic [5:0] ctl;
    logic flag1;
    logic flag2;
    logic line2_out;
    logic line2_oe_n;
    logic [7:0] line_oe_n;
    logic irq_n;
  } ppa_side_s;

  typedef struct packed {
    ppa_bus_s bus_m;
    ppa_bus_s bus_q;
    logic e_d;
    ppa_per_s per_m;
    ppa_per_s per_q;
    logic [1:0] c1_d;
    logic [1:0] c2_d;
    ppa_side_s [1:0] sd;
    logic [7:0] dout;
    logic dout_oe_n;
  } ppa_state_s;

endpackage

/* src/ppa_adapter.sv */
`timescale 1ns/10ps
module ppa_adapter (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic bus_enable,
  input wire logic chip_select_high_0,
  input wire logic chip_select_high_1,
  input wire logic chip_select_low_n,
  input wire logic register_select_low,
  input wire logic register_select_high,
  input wire logic read_write,
  input wire logic [7:0] data_in,
  output logic [7:0] data_out,
  output logic data_oe_n,
  input wire logic [7:0] side_a_peripheral_lines_in,
  output logic [7:0] side_a_peripheral_lines_out,
  output logic [7:0] side_a_peripheral_lines_oe_n,
  input wire logic [7:0] side_b_peripheral_lines_in,
  output logic [7:0] side_b_peripheral_lines_out,
  output logic [7:0] side_b_peripheral_lines_oe_n,
  input wire logic side_a_irq_input,
  input wire logic side_b_irq_input,
  input wire logic side_a_strobe_line_in,
  output logic side_a_strobe_line_out,
  output logic side_a_strobe_line_oe_n,
  input wire logic side_b_strobe_line_in,
  output logic side_b_strobe_line_out,
  output logic side_b_strobe_line_oe_n,
  output logic side_a_interrupt_request_n,
  output logic side_b_interrupt_request_n
);
  import ppa_pkg::*;

  ppa_state_s r;
  ppa_state_s n;
  logic e_fall;
  logic sel;
  logic [1:0] c1_edge;
  logic [1:0] c2_edge;
  logic [1:0] rd_out;
  logic [1:0] wr_out;
  logic [1:0] wr_ctl;
  logic [1:0] wr_ddr;

  // Input pins read back where the direction bit makes them inputs.
  function automatic logic [7:0] port_value(input logic [7:0] outr, input logic [7:0] ddr, input logic [7:0] pin);
    port_value = (outr & ddr) | (pin & ~ddr);
  endfunction

  function automatic ppa_state_s reset_state();
    ppa_state_s s;
    s = '0;
    for (int i = 0; i < 2; i++) begin
      s.sd[i].ddr = REG_RESET;
      s.sd[i].outr = REG_RESET;
      s.sd[i].ctl = CTL_RESET;
      s.sd[i].line2_out = 1'b1;
      s.sd[i].line2_oe_n = 1'b1;
      s.sd[i].line_oe_n = ~REG_RESET;
      s.sd[i].irq_n = 1'b1;
    end
    s.dout_oe_n = 1'b1;
    s.e_d = 1'b0;
    return s;
  endfunction

  always_comb begin
    logic [7:0] pin;
    logic c1;
    logic c2;
    logic hit;
    logic start;
    pin = '0;
    c1 = 1'b0;
    c2 = 1'b0;
    hit = 1'b0;
    start = 1'b0;
    n = r;
    c1_edge = '0;
    c2_edge = '0;
    rd_out = '0;
    wr_out = '0;
    wr_ctl = '0;
    wr_ddr = '0;
    // Every pin passes two flops; edges are taken only from the second stage.
    n.bus_m = '{e: bus_enable, cs0: chip_select_high_0, cs1: chip_select_high_1, cs2_n: chip_select_low_n,
                rs0: register_select_low, rs1: register_select_high, rw: read_write, d: data_in};
    n.bus_q = r.bus_m;
    n.per_m = '{pa: side_a_peripheral_lines_in, pb: side_b_peripheral_lines_in,
                c1: {side_b_irq_input, side_a_irq_input}, c2: {side_b_strobe_line_in, side_a_strobe_line_in}};
    n.per_q = r.per_m;
    n.e_d = r.bus_q.e;
    n.c1_d = r.per_q.c1;
    n.c2_d = r.per_q.c2;
    // Accesses take effect on the falling edge of the enable strobe, as on the original bus.
    e_fall = r.e_d & ~r.bus_q.e;
    sel = r.bus_q.cs0 & r.bus_q.cs1 & ~r.bus_q.cs2_n;
    for (int s = 0; s < 2; s++) begin
      c1 = r.per_q.c1[s];
      c2 = r.per_q.c2[s];
      c1_edge[s] = r.sd[s].ctl[CTL_IRQ1_RISE] ? (c1 & ~r.c1_d[s]) : (~c1 & r.c1_d[s]);
      c2_edge[s] = ~r.sd[s].ctl[CTL_LINE2_OUT] &
                   (r.sd[s].ctl[CTL_LINE2_B4] ? (c2 & ~r.c2_d[s]) : (~c2 & r.c2_d[s]));
      hit = sel & e_fall & (r.bus_q.rs1 == s[0]);
      rd_out[s] = hit & r.bus_q.rw & ~r.bus_q.rs0 & r.sd[s].ctl[CTL_VIEW_OUT];
      wr_out[s] = hit & ~r.bus_q.rw & ~r.bus_q.rs0 & r.sd[s].ctl[CTL_VIEW_OUT];
      wr_ddr[s] = hit & ~r.bus_q.rw & ~r.bus_q.rs0 & ~r.sd[s].ctl[CTL_VIEW_OUT];
      wr_ctl[s] = hit & ~r.bus_q.rw & r.bus_q.rs0;
      // Clearing comes first so that an edge in the same cycle still sets the flag.
      if (rd_out[s]) begin
        n.sd[s].flag1 = 1'b0;
        n.sd[s].flag2 = 1'b0;
      end
      if (c1_edge[s]) begin
        n.sd[s].flag1 = 1'b1;
      end
      if (c2_edge[s]) begin
        n.sd[s].flag2 = 1'b1;
      end
      if (wr_out[s]) begin
        n.sd[s].outr = r.bus_q.d;
      end
      if (wr_ddr[s]) begin
        n.sd[s].ddr = r.bus_q.d;
      end
      if (wr_ctl[s]) begin
        n.sd[s].ctl = r.bus_q.d[CTL_WR_BITS-1:0];
      end
      n.sd[s].line_oe_n = ~n.sd[s].ddr;
      n.sd[s].line2_oe_n = ~n.sd[s].ctl[CTL_LINE2_OUT];
      // Side A strobes on reads and side B on writes only; software uses dummy accesses otherwise.
      start = (s == 0) ? rd_out[s] : wr_out[s];
      if (!n.sd[s].ctl[CTL_LINE2_OUT]) begin
        n.sd[s].line2_out = 1'b1;
      end else if (n.sd[s].ctl[CTL_LINE2_B4]) begin
        n.sd[s].line2_out = n.sd[s].ctl[CTL_LINE2_B3];
      end else if (start) begin
        n.sd[s].line2_out = 1'b0;
      end else if (r.sd[s].ctl[CTL_LINE2_B3] && e_fall) begin
        n.sd[s].line2_out = 1'b1;
      end else if (!r.sd[s].ctl[CTL_LINE2_B3] && c1_edge[s]) begin
        n.sd[s].line2_out = 1'b1;
      end
      n.sd[s].irq_n = ~((n.sd[s].flag1 & n.sd[s].ctl[CTL_IRQ1_EN]) |
                        (n.sd[s].flag2 & n.sd[s].ctl[CTL_LINE2_B3] & ~n.sd[s].ctl[CTL_LINE2_OUT]));
    end
    // The bus is driven only while a selected read holds the enable strobe high.
    n.dout_oe_n = ~(sel & r.bus_q.e & r.bus_q.rw);
    if (r.bus_q.rs0) begin
      n.dout = {r.sd[r.bus_q.rs1].flag1, r.sd[r.bus_q.rs1].flag2, r.sd[r.bus_q.rs1].ctl};
    end else if (r.sd[r.bus_q.rs1].ctl[CTL_VIEW_OUT]) begin
      pin = r.bus_q.rs1 ? r.per_q.pb : r.per_q.pa;
      n.dout = port_value(r.sd[r.bus_q.rs1].outr, r.sd[r.bus_q.rs1].ddr, pin);
    end else begin
      n.dout = r.sd[r.bus_q.rs1].ddr;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      r <= reset_state();
    end else if (clk_en) begin
      r <= n;
    end
  end

  assign data_out = r.dout;
  assign data_oe_n = r.dout_oe_n;
  assign side_a_peripheral_lines_out = r.sd[SIDE_A].outr;
  assign side_a_peripheral_lines_oe_n = r.sd[SIDE_A].line_oe_n;
  assign side_b_peripheral_lines_out = r.sd[SIDE_B].outr;
  assign side_b_peripheral_lines_oe_n = r.sd[SIDE_B].line_oe_n;
  assign side_a_strobe_line_out = r.sd[SIDE_A].line2_out;
  assign side_a_strobe_line_oe_n = r.sd[SIDE_A].line2_oe_n;
  assign side_b_strobe_line_out = r.sd[SIDE_B].line2_out;
  assign side_b_strobe_line_oe_n = r.sd[SIDE_B].line2_oe_n;
  assign side_a_interrupt_request_n = r.sd[SIDE_A].irq_n;
  assign side_b_interrupt_request_n = r.sd[SIDE_B].irq_n;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_flag1_set: assert property (clk_en && c1_edge[0] |=> r.sd[0].flag1)
    else $error("Side A line 1 edge did not set its flag.");
  a_irq_gate: assert property (!side_b_interrupt_request_n == ((r.sd[1].flag1 && r.sd[1].ctl[CTL_IRQ1_EN]) ||
                               (r.sd[1].flag2 && r.sd[1].ctl[CTL_LINE2_B3] && !r.sd[1].ctl[CTL_LINE2_OUT])))
    else $error("Side B interrupt request does not follow flag and enable.");
  a_flag_poll: assert property (clk_en && sel && r.bus_q.e && r.bus_q.rw && r.bus_q.rs0 && !r.bus_q.rs1
                                |=> !data_oe_n && data_out[CTL_FLAG1] == $past(r.sd[0].flag1))
    else $error("Control read does not show the line 1 flag in bit 7.");
  a_view_select: assert property (clk_en && sel && r.bus_q.e && r.bus_q.rw && !r.bus_q.rs0 && r.bus_q.rs1 &&
                                  !r.sd[1].ctl[CTL_VIEW_OUT] |=> data_out == $past(r.sd[1].ddr))
    else $error("Data location with view bit clear did not return direction bits.");
  a_line_dir: assert property (side_a_peripheral_lines_oe_n == ~r.sd[0].ddr)
    else $error("Side A line enables disagree with direction bits.");
  a_pulse_strobe: assert property (clk_en && rd_out[0] && r.sd[0].ctl[5:3] == 3'b101
                                   |=> !side_a_strobe_line_out ##1 (!e_fall || !clk_en)[*1])
    else $error("Side A read did not lower the strobe line.");
  a_pulse_restore: assert property (clk_en && e_fall && !rd_out[0] && r.sd[0].ctl[5:3] == 3'b101 &&
                                    n.sd[0].ctl[5:3] == 3'b101 |=> side_a_strobe_line_out)
    else $error("Side A strobe not restored by the next enable strobe.");
  a_hs_write: assert property (clk_en && wr_out[1] && r.sd[1].ctl[5:3] == 3'b100
                               |=> !side_b_strobe_line_out)
    else $error("Side B write did not lower the strobe line.");
  a_hs_restore: assert property (clk_en && c1_edge[1] && !wr_out[1] && !wr_ctl[1] && r.sd[1].ctl[5:3] == 3'b100
                                 |=> side_b_strobe_line_out)
    else $error("Side B strobe not restored by line 1 edge.");
  a_ro_flags: assert property (clk_en && wr_ctl[0] && !c1_edge[0] && !c2_edge[0] && !rd_out[0]
                               |=> r.sd[0].flag1 == $past(r.sd[0].flag1) && r.sd[0].flag2 == $past(r.sd[0].flag2) &&
                                   r.sd[0].ctl == $past(r.bus_q.d[5:0]))
    else $error("Control write disturbed read-only flags or lost written bits.");
  a_reset_clear: assert property (@(posedge clk) disable iff (1'b0) !rst_n
                                  |=> r.sd[0].ddr == 8'h00 && r.sd[1].ddr == 8'h00 && r.sd[0].ctl == 6'h00 &&
                                      r.sd[1].ctl == 6'h00 && !r.sd[0].flag1 && !r.sd[1].flag2)
    else $error("Reset did not clear the registers.");
  a_read_clears: assert property (clk_en && rd_out[0] && !c1_edge[0] && !c2_edge[0]
                                  |=> !r.sd[0].flag1 && !r.sd[0].flag2)
    else $error("Output register read did not clear the flags.");

  c_irq_raised: cover property (side_a_interrupt_request_n ##1 !side_a_interrupt_request_n);
  c_pulse_seen: cover property (!side_a_strobe_line_out ##[1:200] side_a_strobe_line_out);
  c_hs_seen: cover property (clk_en && wr_out[1] ##[1:400] clk_en && c1_edge[1]);
  c_set_wins: cover property (clk_en && rd_out[0] && c1_edge[0]);

endmodule // ppa_adapter

/* testbench/ppa_peer.sv */
`timescale 1ns/10ps
module ppa_peer (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic a_ready,
  input wire logic b_strobe,
  output logic a_irq,
  output logic b_irq
);
  logic [4:0] cnt_r;
  logic b_strobe_d;
  // The acknowledge comes late on purpose, so the bench can see the line held low first.
  always_ff @(posedge clk) begin
    b_strobe_d <= b_strobe;
    a_irq <= a_ready;
    if (!rst_n) begin
      cnt_r <= 5'h00;
    end else if (b_strobe_d && !b_strobe) begin
      cnt_r <= 5'h01;
    end else if (cnt_r != 5'h00) begin
      cnt_r <= cnt_r + 5'h01;
    end
    b_irq <= !rst_n || !(cnt_r >= 5'h0C && cnt_r < 5'h14);
  end
endmodule // ppa_peer

/* testbench/parallel_port_adapter_control_bench.sv */
`timescale 1ns/10ps
module parallel_port_adapter_control_bench;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic e = 1'b0;
  logic cs0 = 1'b1;
  logic cs1 = 1'b1;
  logic cs2_n = 1'b0;
  logic rs0 = 1'b0;
  logic rs1 = 1'b0;
  logic rw = 1'b1;
  logic a_ready = 1'b0;
  logic [7:0] din = 8'h00;
  logic [7:0] dout, pa_out, pa_oe_n, pb_out, pb_oe_n, pa_in, pb_in, rd;
  logic doe_n, sa_out, sa_oe_n, sb_out, sb_oe_n, irq_a_n, irq_b_n, a_irq, b_irq, last_oe;
  int errors = 0;
  int n_checks = 0;
  int cyc = 0;
  // Undriven lines show the peripheral's byte (5A on side A, 3C on side B); driven lines follow the device.
  assign pa_in = (pa_out & ~pa_oe_n) | (8'h5A & pa_oe_n);
  assign pb_in = (pb_out & ~pb_oe_n) | (8'h3C & pb_oe_n);
  always #2.5 clk = ~clk;
  ppa_adapter i_dut (.clk(clk), .rst_n(rst_n), .clk_en(1'b1), .bus_enable(e), .chip_select_high_0(cs0),
    .chip_select_high_1(cs1), .chip_select_low_n(cs2_n), .register_select_low(rs0),
    .register_select_high(rs1), .read_write(rw), .data_in(din), .data_out(dout), .data_oe_n(doe_n),
    .side_a_peripheral_lines_in(pa_in), .side_a_peripheral_lines_out(pa_out),
    .side_a_peripheral_lines_oe_n(pa_oe_n), .side_b_peripheral_lines_in(pb_in),
    .side_b_peripheral_lines_out(pb_out), .side_b_peripheral_lines_oe_n(pb_oe_n),
    .side_a_irq_input(a_irq), .side_b_irq_input(b_irq), .side_a_strobe_line_in(1'b1),
    .side_a_strobe_line_out(sa_out), .side_a_strobe_line_oe_n(sa_oe_n), .side_b_strobe_line_in(1'b1),
    .side_b_strobe_line_out(sb_out), .side_b_strobe_line_oe_n(sb_oe_n),
    .side_a_interrupt_request_n(irq_a_n), .side_b_interrupt_request_n(irq_b_n));
  ppa_peer i_peer (.clk(clk), .rst_n(rst_n), .a_ready(a_ready), .b_strobe(sb_out), .a_irq(a_irq),
    .b_irq(b_irq));

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One bus cycle; the address is held well past the enable fall as the synchroniser needs.
  task automatic acc(input logic s1, input logic s0, input logic r, input logic [7:0] wd);
    @(posedge clk);
    rs1 <= s1;
    rs0 <= s0;
    rw <= r;
    din <= wd;
    e <= 1'b1;
    repeat (5) @(posedge clk);
    #1;
    // A data bus that nobody drives reads as all ones, as with pull-ups on the board.
    rd = doe_n ? 8'hFF : dout;
    last_oe = doe_n;
    @(posedge clk);
    e <= 1'b0;
    repeat (5) @(posedge clk);
    #1;
  endtask

  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      errors++;
      print_verdict();
    end
  end

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    acc(0, 1, 1, 8'h00); chk(rd, 8'h00);
    acc(0, 0, 1, 8'h00); chk(rd, 8'h00);
    chk(pa_oe_n, 8'hFF);
    chk({5'h00, sa_oe_n, irq_a_n, irq_b_n}, 8'h07);
    $display("test reset done");
    acc(1, 1, 0, 8'hC0); acc(1, 1, 1, 8'h00); chk(rd, 8'h00);
    acc(1, 0, 0, 8'hFF); acc(1, 0, 1, 8'h00); chk(rd, 8'hFF);
    chk(pb_oe_n, 8'h00);
    acc(1, 1, 0, 8'h24); acc(1, 0, 0, 8'hA5);
    chk(pb_out, 8'hA5);
    chk({6'h00, sb_oe_n, sb_out}, 8'h00);
    repeat (30) @(posedge clk);
    chk({7'h00, sb_out}, 8'h01);
    acc(1, 1, 1, 8'h00); chk(rd, 8'hA4);
    chk({7'h00, irq_b_n}, 8'h01);
    acc(1, 0, 1, 8'h00); chk(rd, 8'hA5);
    acc(1, 1, 1, 8'h00); chk(rd, 8'h24);
    $display("test side b handshake done");
    acc(0, 1, 0, 8'h2F); acc(0, 1, 1, 8'h00); chk(rd, 8'h2F);
    a_ready <= 1'b1;
    repeat (10) @(posedge clk);
    #1;
    chk({7'h00, irq_a_n}, 8'h00);
    acc(0, 1, 1, 8'h00); chk(rd, 8'hAF);
    acc(0, 0, 1, 8'h00); chk(rd, 8'h5A);
    chk({6'h00, sa_oe_n, sa_out}, 8'h00);
    chk({7'h00, irq_a_n}, 8'h01);
    acc(0, 1, 1, 8'h00); chk(rd, 8'h2F);
    chk({7'h00, sa_out}, 8'h01);
    acc(0, 0, 0, 8'h96); chk(pa_out, 8'h96);
    chk({7'h00, sa_out}, 8'h01);
    $display("test side a strobe done");
    acc(0, 1, 0, 8'h27); acc(0, 0, 1, 8'h00); chk(rd, 8'h5A);
    chk({7'h00, sa_out}, 8'h00);
    a_ready <= 1'b0;
    repeat (10) @(posedge clk);
    a_ready <= 1'b1;
    repeat (10) @(posedge clk);
    #1;
    chk({7'h00, sa_out}, 8'h01);
    chk({7'h00, irq_a_n}, 8'h00);
    acc(0, 0, 1, 8'h00); chk(rd, 8'h5A);
    acc(0, 1, 0, 8'h2F);
    $display("test side a handshake done");
    cs0 <= 1'b0;
    acc(0, 1, 0, 8'h00);
    acc(0, 1, 1, 8'h00); chk({7'h00, last_oe}, 8'h01);
    cs0 <= 1'b1;
    cs1 <= 1'b0;
    acc(0, 1, 0, 8'h00);
    acc(0, 1, 1, 8'h00); chk({7'h00, last_oe}, 8'h01);
    cs1 <= 1'b1;
    cs2_n <= 1'b1;
    acc(0, 1, 0, 8'h00);
    acc(0, 1, 1, 8'h00); chk({7'h00, last_oe}, 8'h01);
    cs2_n <= 1'b0;
    acc(0, 1, 1, 8'h00); chk(rd, 8'h2F);
    $display("test select done");
    print_verdict();
  end
endmodule // parallel_port_adapter_control_bench
